// ===== include/wolf_defines.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 wake-on-LAN receive filter. Included by bare name; definitions only.
*/
// Operation
// - Release bit clears level-mode wake output
// - Pulse length code selects 8 to 64 wake-rate ticks
// - Style bit picks level or pulse mode
// - Extended enable gates all receive detection
// - Password check demands matching 48-bit password
// - Unicast enable wakes on address match
// - Broadcast enable wakes on broadcast, resets set
// - Pattern enable wakes on pattern match
// - Magic enable wakes on magic packet
// - Status flags latch, clear on read
// - Wrong delimiter byte sets delimiter error
// - CRC failure sets bad checksum flag
// - Password mismatch sets violation flag
// - Unicast match sets unicast received flag
// - Broadcast frame sets broadcast received flag
// - Pattern frame sets pattern received flag
// - Magic packet sets magic received flag
// - Match address in three words, reset zero
// - Password low word read-write, reset zero
// - Password mid and high words, reset zero
`ifndef WOLF_DEFINES_SVH
`define WOLF_DEFINES_SVH
////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define WOLF_OFS_CFG  16'h0134
`define WOLF_OFS_STS  16'h0135
`define WOLF_OFS_ADRL 16'h0136
`define WOLF_OFS_ADRM 16'h0137
`define WOLF_OFS_ADRH 16'h0138
`define WOLF_OFS_PWL  16'h0139
`define WOLF_OFS_PWM  16'h013A
`define WOLF_OFS_PWH  16'h013B
// Reset values and writable masks
`define WOLF_CFG_RESET  16'h0004
`define WOLF_CFG_MASK   16'h0FB7
`define WOLF_STS_RESET  8'h00
`define WOLF_WORD_RESET 16'h0000
// Configuration fields
`define WOLF_B_RELEASE 11
`define WOLF_B_LEN_HI  10
`define WOLF_B_LEN_LO  9
`define WOLF_B_STYLE   8
`define WOLF_B_EXT     7
`define WOLF_B_PWEN    5
`define WOLF_B_UNI     4
`define WOLF_B_BC      2
`define WOLF_B_PAT     1
`define WOLF_B_MAG     0
// Status fields
`define WOLF_S_DELIM 7
`define WOLF_S_CRC   6
`define WOLF_S_PWV   5
`define WOLF_S_UNI   4
`define WOLF_S_BC    2
`define WOLF_S_PAT   1
`define WOLF_S_MAG   0
// Frame constants
`define WOLF_SFD_BYTE    8'h5D
`define WOLF_SYNC_BYTE   8'hFF
`define WOLF_SYNC_LEN    6
`define WOLF_ADDR_REPS   16
`define WOLF_CRC_INIT    32'hFFFFFFFF
`define WOLF_CRC_POLY    32'hEDB88320
`define WOLF_CRC_RESIDUE 32'hDEBB20E3
// Timing: wake pulse counted in ticks of the slower wake rate
`define WOLF_CLK_MHZ    250
`define WOLF_WAKE_MHZ   125
`define WOLF_TICK_DIV   (`WOLF_CLK_MHZ / `WOLF_WAKE_MHZ)
`define WOLF_PULSE_BASE 8
`endif

// ===== include/wolf_pkg.sv
/*
 Types of the wake-on-LAN receive filter: receive byte carrier, magic packet
 states and the state record of each module. Assumes nothing else.
*/
package wolf_pkg;
	// One received byte with its framing marks
	typedef struct packed {
		logic       valid; // Byte present this cycle
		logic       start; // Byte is the frame delimiter
		logic       last;  // Final byte of frame, FCS included
		logic [7:0] data;  // Byte value
	} wolf_rx_byte_t;
	// Magic packet search states
	typedef enum logic [1:0] {
		WOLF_HUNT  = 2'b00,
		WOLF_ADDR  = 2'b01,
		WOLF_PASS  = 2'b10,
		WOLF_MATCH = 2'b11
	} wolf_magic_t;
	// Checksum state
	typedef struct packed {
		logic [31:0] crc;
	} wolf_crc_st_t;
	// Wake output state
	typedef struct packed {
		logic       wake;
		logic [1:0] ph;
		logic [7:0] cnt;
	} wolf_wake_st_t;
	// Filter state
	typedef struct packed {
		logic [15:0] cfg;
		logic [7:0]  sts;
		logic [47:0] adr;
		logic [47:0] pw;
		logic [15:0] rdata;
		logic        in_frame;
		logic        done;
		logic [2:0]  cnt;
		logic        da_uni;
		logic        da_bc;
		logic        pat;
		wolf_magic_t mst;
		logic [2:0]  run;
		logic [2:0]  idx6;
		logic [3:0]  rep;
		logic        pw_bad;
	} wolf_top_st_t;
endpackage : wolf_pkg

// ===== verilog/wolf_crc.sv
/*
 Running Ethernet CRC-32 over received bytes, reflected form.
 Assumes the FCS bytes are shifted in too, so a good frame leaves the residue.
*/
`timescale 1ns/1ps
`include "wolf_defines.svh"
module wolf_crc (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       restart,
	input  wire logic       shift,
	input  wire logic [7:0] data,
	output logic            good
);
	import wolf_pkg::*;
	wolf_crc_st_t s;      // Current checksum
	wolf_crc_st_t next_s; // Next checksum
	// One byte through the reflected polynomial, LSB first
	function automatic logic [31:0] wolf_crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `WOLF_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : wolf_crc_byte
	// Restart on the delimiter, shift on every frame byte
	always_comb begin
		next_s = s;
		if (restart)
			next_s.crc = `WOLF_CRC_INIT;
		else if (shift)
			next_s.crc = wolf_crc_byte(s.crc, data);
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			s <= '0;
		else
			s <= next_s;
	end
	// Residue check
	assign good = (s.crc == `WOLF_CRC_RESIDUE);
endmodule : wolf_crc

// ===== verilog/wolf_wake_out.sv
/*
 Wake output generator: level mode held until released, or pulse mode
 stretched in ticks of the 125-MHz rate. Assumes trigger and release are
 one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`include "wolf_defines.svh"
module wolf_wake_out (
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       trigger,
	input  wire logic       style,
	input  wire logic [1:0] len_code,
	input  wire logic       release_now,
	output logic            wake
);
	import wolf_pkg::*;
	localparam logic [1:0] TICK_LAST = 2'(`WOLF_TICK_DIV - 1);
	wolf_wake_st_t s;      // Current state
	wolf_wake_st_t next_s; // Next state
	logic [7:0]    len;    // Pulse length in ticks
	logic          tick;   // One cycle in each wake-rate period
	logic [8:0]    hi;     // Helper: cycles high since trigger
	logic [8:0]    want;   // Helper: expected high cycles
	assign len  = 8'(`WOLF_PULSE_BASE) << len_code;
	assign tick = (s.ph == TICK_LAST);
	assign want = {len, 1'b0};
	////////////////////////////////////////////////////////////////////////////
	// Mode select and stretch count
	always_comb begin
		next_s    = s;
		next_s.ph = tick ? 2'h0 : 2'(s.ph + 2'h1);
		if (style) begin
			// Level: set wins over release
			next_s.cnt = 8'h00;
			if (trigger)
				next_s.wake = 1'b1;
			else if (release_now)
				next_s.wake = 1'b0;
		end else begin
			// Pulse: release has no effect
			if (trigger) begin
				next_s.cnt  = len;
				next_s.wake = 1'b1;
			end else if (s.cnt == 8'h00) begin
				next_s.wake = 1'b0;
			end else if (tick) begin
				next_s.cnt = 8'(s.cnt - 8'h01);
				if (s.cnt == 8'h01)
					next_s.wake = 1'b0;
			end
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			s <= '0;
		else
			s <= next_s;
	end
	assign wake = s.wake;
	// Helper counter of high cycles
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			hi <= 9'h000;
		else if (trigger || !s.wake)
			hi <= 9'h000;
		else
			hi <= 9'(hi + 9'h001);
	end
	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_pulse_len;
		@(posedge clock) disable iff (!rst_b)
		$fell(s.wake) && !style && $stable(len_code) && $stable(style) |-> (hi + 9'h001 >= want) && (hi <= want);
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("wake pulse length wrong");
	property p_level_hold;
		@(posedge clock) disable iff (!rst_b)
		s.wake && style && !release_now |=> s.wake;
	endproperty
	a_level_hold: assert property (p_level_hold) else $error("level wake dropped");
endmodule : wolf_wake_out

// ===== verilog/wolf_top.sv
/*
 Wake-on-LAN receive filter: register file, frame inspection for unicast,
 broadcast, pattern and magic packets, status flags and wake output.
 Assumes received bytes and the pattern-hit pulse come from logic on the
 same clock, and a gap of at least one idle cycle between frames.
*/
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "wolf_defines.svh"
module wolf_top (
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic [15:0]           addr,
	input  wire logic [15:0]           wdata,
	input  wire logic                  wr,
	input  wire logic                  rd,
	input  wire wolf_pkg::wolf_rx_byte_t rx,
	input  wire logic                  pattern_hit,
	output logic [15:0]                rdata,
	output logic                       wake_out
);
	import wolf_pkg::*;
	wolf_top_st_t s;       // Current state
	wolf_top_st_t next_s;  // Next state
	logic [7:0]   set_v;   // Status events this cycle
	logic [7:0]   en_v;    // Wake enables aligned with status
	logic [7:0]   clr_v;   // Status bits cleared by a read
	logic [15:0]  rd_word; // Read multiplexer
	logic         ext;     // Extended receive enable
	logic         trig;    // Wake trigger
	logic         crc_ok;  // Checksum residue good
	logic         rd_sts;  // Status register read
	logic [7:0]   d;       // Current receive byte
	////////////////////////////////////////////////////////////////////////////
	// Byte i of a 48-bit word, byte 0 being bits 47:40
	function automatic logic [7:0] wolf_pick(input logic [47:0] v, input logic [2:0] i);
		return v[8 * (5 - i) +: 8];
	endfunction : wolf_pick
	// Offset decode
	function automatic logic wolf_hit(input logic [15:0] a, input logic [15:0] ofs);
		return (a == ofs);
	endfunction : wolf_hit
	assign ext    = s.cfg[`WOLF_B_EXT];
	assign d      = rx.data;
	assign rd_sts = rd && wolf_hit(addr, `WOLF_OFS_STS);
	assign clr_v  = rd_sts ? 8'hFF : 8'h00;
	////////////////////////////////////////////////////////////////////////////
	// Checksum over the frame bytes that follow the delimiter
	wolf_crc u_crc (
		.clock   (clock),
		.rst_b   (rst_b),
		.restart (rx.valid && rx.start),
		.shift   (rx.valid && !rx.start && s.in_frame),
		.data    (d),
		.good    (crc_ok)
	);
	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer; reserved bits and unmapped offsets read zero
	always_comb begin
		case (addr)
			`WOLF_OFS_CFG:  rd_word = s.cfg;
			`WOLF_OFS_STS:  rd_word = {8'h00, s.sts};
			`WOLF_OFS_ADRL: rd_word = s.adr[15:0];
			`WOLF_OFS_ADRM: rd_word = s.adr[31:16];
			`WOLF_OFS_ADRH: rd_word = s.adr[47:32];
			`WOLF_OFS_PWL:  rd_word = s.pw[15:0];
			`WOLF_OFS_PWM:  rd_word = s.pw[31:16];
			`WOLF_OFS_PWH:  rd_word = s.pw[47:32];
			default:        rd_word = 16'h0000;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	// Wake enables in status bit order
	always_comb begin
		en_v              = 8'h00;
		en_v[`WOLF_S_UNI] = s.cfg[`WOLF_B_UNI];
		en_v[`WOLF_S_BC]  = s.cfg[`WOLF_B_BC];
		en_v[`WOLF_S_PAT] = s.cfg[`WOLF_B_PAT];
		en_v[`WOLF_S_MAG] = s.cfg[`WOLF_B_MAG];
	end
	assign trig = ext && |(set_v & en_v);
	////////////////////////////////////////////////////////////////////////////
	// Registers, frame inspection and status events
	always_comb begin
		next_s       = s;
		set_v        = 8'h00;
		next_s.done  = 1'b0;
		next_s.rdata = 16'h0000;
		// Self-clearing release bit
		next_s.cfg[`WOLF_B_RELEASE] = 1'b0;
		// Read data stand for one cycle
		if (rd)
			next_s.rdata = rd_word;
		// Register writes; status is read only
		if (wr) begin
			case (addr)
				`WOLF_OFS_CFG:  next_s.cfg        = wdata & `WOLF_CFG_MASK;
				`WOLF_OFS_ADRL: next_s.adr[15:0]  = wdata;
				`WOLF_OFS_ADRM: next_s.adr[31:16] = wdata;
				`WOLF_OFS_ADRH: next_s.adr[47:32] = wdata;
				`WOLF_OFS_PWL:  next_s.pw[15:0]   = wdata;
				`WOLF_OFS_PWM:  next_s.pw[31:16]  = wdata;
				`WOLF_OFS_PWH:  next_s.pw[47:32]  = wdata;
				default:        next_s.cfg        = s.cfg;
			endcase
			next_s.cfg[`WOLF_B_RELEASE] = wolf_hit(addr, `WOLF_OFS_CFG) && wdata[`WOLF_B_RELEASE];
		end
		// Byte stream, only with extended receive on
		if (rx.valid && ext) begin
			if (rx.start) begin
				// Delimiter byte opens a frame or flags an error
				next_s.in_frame = (d == `WOLF_SFD_BYTE);
				if (d != `WOLF_SFD_BYTE)
					set_v[`WOLF_S_DELIM] = 1'b1;
				next_s.cnt    = 3'h0;
				next_s.da_uni = 1'b1;
				next_s.da_bc  = 1'b1;
				next_s.pat    = 1'b0;
				next_s.mst    = WOLF_HUNT;
				next_s.run    = 3'h0;
				next_s.idx6   = 3'h0;
				next_s.rep    = 4'h0;
				next_s.pw_bad = 1'b0;
			end else if (s.in_frame) begin
				// Destination address, first six bytes
				if (s.cnt < 3'h6) begin
					if (d != wolf_pick(s.adr, s.cnt))
						next_s.da_uni = 1'b0;
					if (d != `WOLF_SYNC_BYTE)
						next_s.da_bc = 1'b0;
					next_s.cnt = 3'(s.cnt + 3'h1);
				end
				// Magic packet search
				case (s.mst)
					WOLF_HUNT: begin
						if (s.run == 3'(`WOLF_SYNC_LEN) && d == wolf_pick(s.adr, 3'h0)) begin
							next_s.mst  = WOLF_ADDR;
							next_s.idx6 = 3'h1;
							next_s.rep  = 4'h0;
						end else if (d == `WOLF_SYNC_BYTE) begin
							if (s.run != 3'(`WOLF_SYNC_LEN))
								next_s.run = 3'(s.run + 3'h1);
						end else begin
							next_s.run = 3'h0;
						end
					end
					WOLF_ADDR: begin
						if (d != wolf_pick(s.adr, s.idx6)) begin
							// Broken copy: hunt again
							next_s.mst = WOLF_HUNT;
							next_s.run = (d == `WOLF_SYNC_BYTE) ? 3'h1 : 3'h0;
						end else if (s.idx6 == 3'h5) begin
							next_s.idx6 = 3'h0;
							if (s.rep == 4'(`WOLF_ADDR_REPS - 1))
								next_s.mst = s.cfg[`WOLF_B_PWEN] ? WOLF_PASS : WOLF_MATCH;
							else
								next_s.rep = 4'(s.rep + 4'h1);
						end else begin
							next_s.idx6 = 3'(s.idx6 + 3'h1);
						end
					end
					WOLF_PASS: begin
						// Password bytes after the address copies
						if (d != wolf_pick(s.pw, s.idx6))
							next_s.pw_bad = 1'b1;
						if (s.idx6 == 3'h5) begin
							next_s.idx6 = 3'h0;
							next_s.mst  = WOLF_MATCH;
						end else begin
							next_s.idx6 = 3'(s.idx6 + 3'h1);
						end
					end
					WOLF_MATCH: next_s.mst = WOLF_MATCH;
					default:    next_s.mst = WOLF_HUNT;
				endcase
				// Frame end: judge in the next cycle
				if (rx.last) begin
					next_s.in_frame = 1'b0;
					next_s.done     = 1'b1;
				end
			end
		end
		// Pattern matcher reports inside the frame
		if (pattern_hit && s.in_frame)
			next_s.pat = 1'b1;
		// Frame verdict once the checksum has settled
		if (s.done && ext) begin
			if (!crc_ok) begin
				set_v[`WOLF_S_CRC] = 1'b1;
			end else begin
				set_v[`WOLF_S_BC]  = s.da_bc;
				set_v[`WOLF_S_UNI] = s.da_uni;
				set_v[`WOLF_S_PAT] = s.pat;
				if (s.mst == WOLF_MATCH) begin
					if (s.cfg[`WOLF_B_PWEN] && s.pw_bad)
						set_v[`WOLF_S_PWV] = 1'b1;
					else
						set_v[`WOLF_S_MAG] = 1'b1;
				end else if (s.mst == WOLF_PASS && s.cfg[`WOLF_B_PWEN]) begin
					set_v[`WOLF_S_PWV] = 1'b1;
				end
			end
		end
		// Latch high, clear on read, set wins
		next_s.sts = (s.sts & ~clr_v) | set_v;
	end
	////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s     <= '0;
			s.cfg <= `WOLF_CFG_RESET;
		end else begin
			s <= next_s;
		end
	end
	assign rdata = s.rdata;
	////////////////////////////////////////////////////////////////////////////
	// Wake output
	wolf_wake_out u_wake (
		.clock       (clock),
		.rst_b       (rst_b),
		.trigger     (trig),
		.style       (s.cfg[`WOLF_B_STYLE]),
		.len_code    (s.cfg[`WOLF_B_LEN_HI:`WOLF_B_LEN_LO]),
		.release_now (s.cfg[`WOLF_B_RELEASE]),
		.wake        (wake_out)
	);
	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_delim;
		@(posedge clock) disable iff (!rst_b)
		rx.valid && rx.start && ext && rx.data != `WOLF_SFD_BYTE |=> s.sts[`WOLF_S_DELIM];
	endproperty
	a_delim: assert property (p_delim) else $error("delimiter error not flagged");
	property p_crc;
		@(posedge clock) disable iff (!rst_b)
		s.done && ext && !crc_ok |=> s.sts[`WOLF_S_CRC] && !s.sts[`WOLF_S_MAG];
	endproperty
	a_crc: assert property (p_crc) else $error("bad checksum not flagged");
	property p_rdclr;
		@(posedge clock) disable iff (!rst_b)
		rd_sts && set_v == 8'h00 |=> s.sts == 8'h00;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("status not cleared by read");
	property p_rdval;
		@(posedge clock) disable iff (!rst_b)
		rd_sts |=> rdata[15:8] == 8'h00 && rdata[7:0] == $past(s.sts);
	endproperty
	a_rdval: assert property (p_rdval) else $error("status read data wrong");
	property p_ext;
		@(posedge clock) disable iff (!rst_b)
		!ext |-> set_v == 8'h00 && !trig;
	endproperty
	a_ext: assert property (p_ext) else $error("event while extended receive off");
	property p_bcwake;
		@(posedge clock) disable iff (!rst_b)
		set_v[`WOLF_S_BC] && s.cfg[`WOLF_B_BC] |=> wake_out;
	endproperty
	a_bcwake: assert property (p_bcwake) else $error("broadcast did not wake");
	property p_pwv;
		@(posedge clock) disable iff (!rst_b)
		set_v[`WOLF_S_PWV] |-> s.cfg[`WOLF_B_PWEN] && !set_v[`WOLF_S_MAG];
	endproperty
	a_pwv: assert property (p_pwv) else $error("violation without password check");
	property p_release;
		@(posedge clock) disable iff (!rst_b)
		s.cfg[`WOLF_B_RELEASE] && s.cfg[`WOLF_B_STYLE] && !trig |=> !wake_out;
	endproperty
	a_release: assert property (p_release) else $error("release did not clear wake");
	property p_uni;
		@(posedge clock) disable iff (!rst_b)
		set_v[`WOLF_S_UNI] |-> s.da_uni && crc_ok && s.done;
	endproperty
	a_uni: assert property (p_uni) else $error("unicast flag without match");
endmodule : wolf_top

// ===== tb/wolf_link_model.sv
/*
 Link side model: plays received frames byte by byte into the filter and
 pulses the pattern matcher hit. Assumes the filter clock as byte clock.
*/
`timescale 1ns/1ps
module wolf_link_model (
	input  wire logic           clock,
	output wolf_pkg::wolf_rx_byte_t rx,
	output logic                pattern_hit
);
	import wolf_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	// Idle line at time zero
	initial begin
		rx          = '0;
		pattern_hit = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Delimiter, then frame bytes; idle data shows the inverse of the last byte
	task automatic send(input logic [7:0] fr[$], input logic [7:0] sfd, input int hit_at);
		for (int i = -1; i < fr.size(); i++) begin
			@(posedge clock);
			rx.valid    <= 1'b1;
			rx.start    <= (i < 0);
			rx.last     <= (i == fr.size() - 1);
			rx.data     <= (i < 0) ? sfd : fr[i];
			pattern_hit <= (i == hit_at);
		end
		@(posedge clock);
		rx          <= {3'b000, ~fr[fr.size() - 1]};
		pattern_hit <= 1'b0;
	endtask : send
endmodule : wolf_link_model

// ===== tb/wolf_top_bench.sv
/*
 Self-checking bench of the receive filter: register access, every wake
 event, error flags and both wake output styles. Assumes the link model.
*/
`timescale 1ns/1ps
`include "wolf_defines.svh"
module wolf_top_bench;
	import wolf_pkg::*;
	logic           clock;       // 250 MHz clock
	logic           rst_b;       // Reset, active low
	logic [15:0]    addr;        // Register offset
	logic [15:0]    wdata;       // Write data
	logic           wr;          // Write strobe
	logic           rd;          // Read strobe
	logic [15:0]    rdata;       // Read data
	logic           wake_out;    // Wake output
	logic           pattern_hit; // Pattern matcher pulse
	wolf_rx_byte_t  rx;          // Received bytes
	int             error_cnt;   // Mismatches
	int             num_checks;  // Comparisons
	int             seed;        // Random seed
	logic [47:0]    mac;         // Configured match address
	logic [47:0]    pw;          // Configured password
	logic [15:0]    d;           // Scratch word
	logic [7:0]     fq[$];       // Frame body without checksum
	////////////////////////////////////////////////////////////////////////////////
	// Design and link model
	wolf_top u_dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rx(rx), .pattern_hit(pattern_hit), .rdata(rdata), .wake_out(wake_out));
	wolf_link_model u_link (.clock(clock), .rx(rx), .pattern_hit(pattern_hit));
	////////////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		#400000;
		error_cnt++;
		end_sim();
	end
	////////////////////////////////////////////////////////////////////////////////
	// Checking helpers
	task automatic chk(input string nm, input logic [47:0] got, input logic [47:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp=%h got=%h", nm, exp, got);
		end
	endtask : chk
	task automatic end_sim();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////////////
	// Register bus: one-cycle strobes, read data in the following cycle
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
		@(posedge clock);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clock);
		wr    <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [15:0] a, output logic [15:0] v);
		@(posedge clock);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clock);
		rd   <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg
	////////////////////////////////////////////////////////////////////////////////
	// Reflected Ethernet checksum, complemented
	function automatic logic [31:0] crc32(input logic [7:0] q[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (q[i]) begin
			c = c ^ {24'h000000, q[i]};
			for (int b = 0; b < 8; b++) begin
				c = c[0] ? ((c >> 1) ^ 32'hEDB88320) : (c >> 1);
			end
		end
		return ~c;
	endfunction : crc32
	// Frame body: kind 0 plain, 1 magic, 2 magic with password p
	task automatic mk(input logic [47:0] da, input int kind, input logic [47:0] p);
		fq.delete();
		for (int i = 5; i >= 0; i--) fq.push_back(da[i*8+:8]);
		repeat (8) fq.push_back(8'($random(seed)));
		if (kind > 0) begin
			repeat (6) fq.push_back(8'hFF);
			repeat (16) for (int i = 5; i >= 0; i--) fq.push_back(mac[i*8+:8]);
		end
		if (kind == 2) begin
			for (int i = 5; i >= 0; i--) fq.push_back(p[i*8+:8]);
		end
		while (fq.size() < 60) fq.push_back(8'($random(seed)));
	endtask : mk
	// Send frame, measure wake, read status twice; wl: -1 level, else ticks
	task automatic frame_case(input logic [7:0] sfd, input bit bad, input int hit,
		input logic [15:0] es, input int wl);
		logic [7:0]  f[$];
		logic [31:0] fcs;
		logic [15:0] s;
		int          cnt;
		f   = fq;
		fcs = crc32(fq) ^ {31'h0, bad};
		for (int i = 0; i < 4; i++) f.push_back(fcs[i*8+:8]);
		u_link.send(f, sfd, hit);
		cnt = 0;
		for (int i = 0; i < 300; i++) begin
			@(posedge clock);
			#1;
			if (wake_out === 1'b1) cnt++;
		end
		if (wl < 0) begin
			chk("wake_level", wake_out, 1'b1);
		end else begin
			chk("wake_len_ok", (wl == 0) ? (cnt == 0) : (cnt == 2 * wl || cnt == 2 * wl - 1), 1'b1);
		end
		rd_reg(`WOLF_OFS_STS, s);
		chk("status", s, es);
		rd_reg(`WOLF_OFS_STS, s);
		chk("status_cleared", s, 16'h0000);
	endtask : frame_case
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		seed = 38;
		rst_b = 1'b0;
		addr = 16'h0000;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		repeat (6) @(posedge clock);
		rst_b <= 1'b1;
		// Reset values, one unmapped offset at the end
		for (int a = 16'h0134; a <= 16'h013C; a++) begin
			rd_reg(16'(a), d);
			chk("reset_value", d, (a == 16'h0134) ? 16'h0004 : 16'h0000);
		end
		// Address and password words read back
		mac = {$random(seed), $random(seed)};
		pw  = {$random(seed), $random(seed)};
		for (int i = 0; i < 6; i++) begin
			d = (i < 3) ? mac[i*16+:16] : pw[(i-3)*16+:16];
			wr_reg(16'(`WOLF_OFS_ADRL + i), d);
			rd_reg(16'(`WOLF_OFS_ADRL + i), wdata);
			chk("word_rw", wdata, d);
		end
		// Status is read only; config reserved bits read zero
		wr_reg(`WOLF_OFS_STS, 16'hFFFF);
		rd_reg(`WOLF_OFS_STS, d);
		chk("status_ro", d, 16'h0000);
		d = 16'($random(seed)) & 16'h07FF;
		wr_reg(`WOLF_OFS_CFG, d);
		rd_reg(`WOLF_OFS_CFG, wdata);
		chk("config_rw", wdata, d & 16'h0FB7);
		// Extended enable clear: nothing inspected
		wr_reg(`WOLF_OFS_CFG, 16'h0004);
		mk(48'hFFFFFFFFFFFF, 0, 0);
		frame_case(8'h5D, 0, -1, 16'h0000, 0);
		// Broadcast under every pulse length code
		for (int c = 0; c < 4; c++) begin
			wr_reg(`WOLF_OFS_CFG, 16'h0084 | 16'(c << 9));
			frame_case(8'h5D, 0, -1, 16'h0004, 8 << c);
		end
		// Broadcast wake disabled: flag only
		wr_reg(`WOLF_OFS_CFG, 16'h0080);
		frame_case(8'h5D, 0, -1, 16'h0004, 0);
		// Unicast hit and miss, checksum and delimiter errors
		wr_reg(`WOLF_OFS_CFG, 16'h0093);
		mk(mac, 0, 0);
		frame_case(8'h5D, 0, -1, 16'h0010, 8);
		frame_case(8'h5D, 1, -1, 16'h0040, 0);
		frame_case(8'h55, 0, -1, 16'h0080, 0);
		mk(mac ^ 48'h1, 0, 0);
		frame_case(8'h5D, 0, -1, 16'h0000, 0);
		// Pattern hit inside a frame
		frame_case(8'h5D, 0, 10, 16'h0002, 8);
		// Magic packets without and with password checking
		mk(mac ^ 48'h4, 1, 0);
		frame_case(8'h5D, 0, -1, 16'h0001, 8);
		wr_reg(`WOLF_OFS_CFG, 16'h00B3);
		mk(mac ^ 48'h4, 2, pw);
		frame_case(8'h5D, 0, -1, 16'h0001, 8);
		mk(mac ^ 48'h4, 2, pw ^ 48'h8000);
		frame_case(8'h5D, 0, -1, 16'h0020, 0);
		// Level style held, then released by software
		wr_reg(`WOLF_OFS_CFG, 16'h0185);
		mk(48'hFFFFFFFFFFFF, 0, 0);
		frame_case(8'h5D, 0, -1, 16'h0004, -1);
		wr_reg(`WOLF_OFS_CFG, 16'h0985);
		repeat (2) @(posedge clock);
		#1;
		chk("wake_released", wake_out, 1'b0);
		end_sim();
	end
endmodule : wolf_top_bench
